//--- core/dpc_pkg.sv
// Constants, register indices and types shared by the priority classifier.
// Assumes a single 25 MHz core clock and 32-bit Avalon-MM register access.
package dpc_pkg;

  // ==========================================================================
  // Widths
  localparam int DPC_ADDR_W    = 10;
  localparam int DPC_DATA_W    = 32;
  localparam int DPC_BE_W      = 4;
  localparam int DPC_IDX_W     = 8;
  localparam int DPC_TBL_BYTES = 16;
  localparam int DPC_TBL_AW    = 4;
  localparam int DPC_BYTE_W    = 8;
  localparam int DPC_FIELD_W   = 2;
  localparam int DPC_SEL_W     = 2;
  localparam int DPC_CODE_W    = 6;
  localparam int DPC_CNT_W     = 16;

  // ==========================================================================
  // Header byte layout: code point is bits 7..2
  localparam int DPC_CODE_HI   = 7;
  localparam int DPC_CODE_LO   = 2;
  localparam int DPC_ROW_HI    = 7;
  localparam int DPC_ROW_LO    = 4;
  localparam int DPC_SEL_HI    = 3;
  localparam int DPC_SEL_LO    = 2;
  localparam int DPC_WORD_LO   = 2;

  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [DPC_IDX_W-1:0] DPC_IDX_MAP_BYTE0 = 8'h60;
  localparam logic [DPC_IDX_W-1:0] DPC_IDX_MAP_BYTE1 = 8'h61;
  localparam logic [DPC_IDX_W-1:0] DPC_IDX_MAP_BYTE2 = 8'h62;
  localparam logic [DPC_IDX_W-1:0] DPC_IDX_MAP_BYTE3 = 8'h63;
  localparam logic [DPC_IDX_W-1:0] DPC_IDX_MAP_BYTE4 = 8'h64;
  localparam logic [DPC_IDX_W-1:0] DPC_IDX_MAP_LAST  = 8'h6f;
  localparam logic [DPC_IDX_W-1:0] DPC_IDX_CTRL      = 8'h70;
  localparam logic [DPC_IDX_W-1:0] DPC_IDX_STATUS    = 8'h71;
  localparam logic [DPC_IDX_W-1:0] DPC_IDX_COUNT     = 8'h72;

  // ==========================================================================
  // Reset values and field positions
  localparam logic [DPC_BYTE_W-1:0]  DPC_MAP_RESET   = 8'h00;
  localparam logic [DPC_FIELD_W-1:0] DPC_PRIO_RESET  = 2'h0;
  localparam logic                   DPC_EN_RESET    = 1'b1;
  localparam logic [DPC_CODE_W-1:0]  DPC_CODE_RESET  = 6'h00;
  localparam logic [DPC_CNT_W-1:0]   DPC_CNT_RESET   = 16'h0000;
  localparam logic [DPC_CNT_W-1:0]   DPC_CNT_ONE     = 16'h0001;
  localparam logic [DPC_DATA_W-1:0]  DPC_DATA_ZERO   = 32'h0000_0000;
  localparam int                     DPC_CTRL_EN_BIT = 0;
  localparam int                     DPC_ST_CODE_LO  = 0;
  localparam int                     DPC_ST_PRIO_LO  = 8;
  localparam int                     DPC_ST_SEEN_BIT = 15;
  localparam int                     DPC_BE_LANE0    = 0;

  // ==========================================================================
  // Bus slave states
  typedef enum logic [1:0] {
    DPC_BUS_IDLE,
    DPC_BUS_WAIT,
    DPC_BUS_DONE
  } dpc_bus_state_t;

endpackage : dpc_pkg

//--- core/dpc_tbl_if.sv
// Interface between the classifier core and its mapping table store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface dpc_tbl_if;
  import dpc_pkg::*;

  logic [DPC_TBL_AW-1:0] a_addr;   // Software port row
  logic                  a_we;     // Software port write strobe
  logic [DPC_BYTE_W-1:0] a_wdata;  // Software port write data
  logic [DPC_BYTE_W-1:0] a_rdata;  // Software port registered read data
  logic [DPC_TBL_AW-1:0] b_addr;   // Lookup port row
  logic [DPC_BYTE_W-1:0] b_rdata;  // Lookup port registered read data

  modport ctrl (output a_addr, output a_we, output a_wdata, input a_rdata,
                output b_addr, input b_rdata);
  modport mem  (input a_addr, input a_we, input a_wdata, output a_rdata,
                input b_addr, output b_rdata);
endinterface : dpc_tbl_if

`default_nettype wire

//--- core/dpc_map_mem.sv
// Mapping table store: sixteen bytes, one write port and two registered reads.
// Assumes a reset already synchronised to clock.
`timescale 1ns/1ps
`default_nettype none

module dpc_map_mem
  import dpc_pkg::*;
(
  input  wire logic clock,  // Core clock
  input  wire logic rst_n,  // Synchronised reset, active low
  dpc_tbl_if.mem    tbl     // Table access ports
);
  import dpc_pkg::*;

  logic [DPC_BYTE_W-1:0] mem_ff [DPC_TBL_BYTES];
  logic [DPC_BYTE_W-1:0] a_rdata_ff;
  logic [DPC_BYTE_W-1:0] b_rdata_ff;

  // ==========================================================================
  // Storage rows
  genvar gi;
  generate
    for (gi = 0; gi < DPC_TBL_BYTES; gi++) begin : g_row
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          mem_ff[gi] <= DPC_MAP_RESET;
        end else if (tbl.a_we && (tbl.a_addr == DPC_TBL_AW'(gi))) begin
          mem_ff[gi] <= tbl.a_wdata;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Registered reads; a same-cycle write is seen one cycle later
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      a_rdata_ff <= DPC_MAP_RESET;
    end else begin
      a_rdata_ff <= mem_ff[tbl.a_addr];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      b_rdata_ff <= DPC_MAP_RESET;
    end else begin
      b_rdata_ff <= mem_ff[tbl.b_addr];
    end
  end

  assign tbl.a_rdata = a_rdata_ff;
  assign tbl.b_rdata = b_rdata_ff;

endmodule // dpc_map_mem

`default_nettype wire

//--- core/dpc_classifier.sv
// Code point to priority classifier with Avalon-MM register slave.
// Assumes header inputs come from logic on the same clock; nrst may be async.
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Decode header bits 7..2 into 64 codes
// - Table is 64 two-bit fields, 128 bits
// - Decoded code selects its table field
// - Field is priority; fields RW, reset 00
// - Byte0 holds codes 0x00..0x0C low-first
// - Byte1 holds codes 0x10..0x1C low-first
// - Byte 0x62 holds codes 0x20..0x2C
// - Byte 0x63 holds codes 0x30..0x3C
// - Following bytes continue, 0x64 holds 0x40..0x4C
module dpc_classifier
  import dpc_pkg::*;
(
  input  wire logic                  clock,            // Core clock, 25 MHz
  input  wire logic                  nrst,             // Reset, active low
  input  wire logic [DPC_ADDR_W-1:0] avs_address,      // Byte address
  input  wire logic                  avs_read,         // Read request
  input  wire logic                  avs_write,        // Write request
  input  wire logic [DPC_DATA_W-1:0] avs_writedata,    // Write data
  input  wire logic [DPC_BE_W-1:0]   avs_byteenable,   // Byte enables
  output logic      [DPC_DATA_W-1:0] avs_readdata,     // Read data
  output logic                       avs_waitrequest,  // Stall, high until answer
  input  wire logic                  hdr_valid,        // Header byte strobe
  input  wire logic                  hdr_is_ip,        // Frame carries IP header
  input  wire logic [DPC_BYTE_W-1:0] hdr_tos,          // Type-of-service byte
  output logic                       prio_valid,       // Priority result pulse
  output logic      [DPC_FIELD_W-1:0] prio_value,      // Priority result
  output logic                       prio_bypass       // Use other source pulse
);
  import dpc_pkg::*;

  // ==========================================================================
  // Reset release
  // Release is synchronised; entry into reset stays asynchronous
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // ==========================================================================
  // Table store
  dpc_tbl_if tbl ();

  dpc_map_mem u_mem (
    .clock (clock),
    .rst_n (rst_n_ff),
    .tbl   (tbl.mem)
  );

  // ==========================================================================
  // Register decode
  dpc_bus_state_t         bus_state_ff;
  logic [DPC_IDX_W-1:0]   reg_idx;
  logic                   hit_map;
  logic                   hit_ctrl;
  logic                   hit_status;
  logic                   hit_count;
  logic                   bus_take;
  logic                   wr_lane0;
  logic [DPC_IDX_W-1:0]   map_row_wide;

  logic                   enable_ff;
  logic [DPC_CODE_W-1:0]  last_code_ff;
  logic [DPC_FIELD_W-1:0] last_prio_ff;
  logic                   seen_ff;
  logic [DPC_CNT_W-1:0]   count_ff;
  logic                   rd_map_ff;
  logic                   rd_ctrl_ff;
  logic                   rd_status_ff;
  logic                   rd_count_ff;
  logic [DPC_DATA_W-1:0]  readdata_ff;
  logic                   waitrequest_ff;

  assign reg_idx      = avs_address[DPC_ADDR_W-1:DPC_WORD_LO];
  assign hit_map      = (reg_idx >= DPC_IDX_MAP_BYTE0) && (reg_idx <= DPC_IDX_MAP_LAST);
  assign hit_ctrl     = (reg_idx == DPC_IDX_CTRL);
  assign hit_status   = (reg_idx == DPC_IDX_STATUS);
  assign hit_count    = (reg_idx == DPC_IDX_COUNT);
  assign bus_take     = (bus_state_ff == DPC_BUS_IDLE) && (avs_read || avs_write);
  assign wr_lane0     = bus_take && avs_write && avs_byteenable[DPC_BE_LANE0];
  assign map_row_wide = reg_idx - DPC_IDX_MAP_BYTE0;

  // Row 0 is byte 0x60, row 2 is 0x62, row 3 is 0x63, row 4 is 0x64
  assign tbl.a_addr  = map_row_wide[DPC_TBL_AW-1:0];
  assign tbl.a_we    = wr_lane0 && hit_map;
  assign tbl.a_wdata = avs_writedata[DPC_BYTE_W-1:0];

  // ==========================================================================
  // Bus slave sequencing: take, fetch, answer for one cycle
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      bus_state_ff <= DPC_BUS_IDLE;
    end else begin
      case (bus_state_ff)
        DPC_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state_ff <= DPC_BUS_WAIT;
          end
        end
        DPC_BUS_WAIT: begin
          bus_state_ff <= DPC_BUS_DONE;
        end
        DPC_BUS_DONE: begin
          bus_state_ff <= DPC_BUS_IDLE;
        end
        default: begin
          bus_state_ff <= DPC_BUS_IDLE;
        end
      endcase
    end
  end

  // Registered stall: the answer lands one edge after the take
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      waitrequest_ff <= 1'b1;
    end else begin
      waitrequest_ff <= (bus_state_ff != DPC_BUS_WAIT);
    end
  end

  // Source of read data, latched when the request is taken
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rd_map_ff    <= 1'b0;
      rd_ctrl_ff   <= 1'b0;
      rd_status_ff <= 1'b0;
      rd_count_ff  <= 1'b0;
    end else if (bus_take) begin
      rd_map_ff    <= avs_read && hit_map;
      rd_ctrl_ff   <= avs_read && hit_ctrl;
      rd_status_ff <= avs_read && hit_status;
      rd_count_ff  <= avs_read && hit_count;
    end
  end

  // ==========================================================================
  // Read-back words, zero above each register's width
  logic [DPC_DATA_W-1:0] map_word;
  logic [DPC_DATA_W-1:0] ctrl_word;
  logic [DPC_DATA_W-1:0] status_word;
  logic [DPC_DATA_W-1:0] count_word;

  always_comb begin
    map_word    = DPC_DATA_ZERO;
    ctrl_word   = DPC_DATA_ZERO;
    status_word = DPC_DATA_ZERO;
    count_word  = DPC_DATA_ZERO;
    map_word[DPC_BYTE_W-1:0]                   = tbl.a_rdata;
    ctrl_word[DPC_CTRL_EN_BIT]                 = enable_ff;
    status_word[DPC_ST_CODE_LO +: DPC_CODE_W]  = last_code_ff;
    status_word[DPC_ST_PRIO_LO +: DPC_FIELD_W] = last_prio_ff;
    status_word[DPC_ST_SEEN_BIT]               = seen_ff;
    count_word[DPC_CNT_W-1:0]                  = count_ff;
  end

  // Unmapped reads and write answers carry zero
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      readdata_ff <= DPC_DATA_ZERO;
    end else if (bus_state_ff == DPC_BUS_WAIT) begin
      if (rd_map_ff) begin
        readdata_ff <= map_word;
      end else if (rd_ctrl_ff) begin
        readdata_ff <= ctrl_word;
      end else if (rd_status_ff) begin
        readdata_ff <= status_word;
      end else if (rd_count_ff) begin
        readdata_ff <= count_word;
      end else begin
        readdata_ff <= DPC_DATA_ZERO;
      end
    end
  end

  // ==========================================================================
  // Control register
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      enable_ff <= DPC_EN_RESET;
    end else if (wr_lane0 && hit_ctrl) begin
      enable_ff <= avs_writedata[DPC_CTRL_EN_BIT];
    end
  end

  // ==========================================================================
  // Lookup pipeline: stage 1 reads the row, stage 2 picks the field
  logic                   s1_valid_ff;
  logic                   s1_ip_ff;
  logic [DPC_SEL_W-1:0]   s1_sel_ff;
  logic [DPC_CODE_W-1:0]  s1_code_ff;
  logic [DPC_FIELD_W-1:0] field_pick;
  logic                   classify_done;

  // A table write at a lookup's first edge returns the old row
  assign tbl.b_addr = hdr_tos[DPC_ROW_HI:DPC_ROW_LO];

  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      s1_valid_ff <= 1'b0;
      s1_ip_ff    <= 1'b0;
      s1_sel_ff   <= '0;
      s1_code_ff  <= DPC_CODE_RESET;
    end else begin
      s1_valid_ff <= hdr_valid;
      s1_ip_ff    <= hdr_is_ip && enable_ff;
      s1_sel_ff   <= hdr_tos[DPC_SEL_HI:DPC_SEL_LO];
      s1_code_ff  <= hdr_tos[DPC_CODE_HI:DPC_CODE_LO];
    end
  end

  // Lowest code of a row sits in bits 1..0, highest in bits 7..6
  localparam int FIELDS_PER_ROW = DPC_BYTE_W / DPC_FIELD_W;

  wire logic [FIELDS_PER_ROW-1:0]                  sel_hot;
  wire logic [FIELDS_PER_ROW-1:0][DPC_FIELD_W-1:0] field_raw;
  wire logic [FIELDS_PER_ROW:0][DPC_FIELD_W-1:0]   field_acc;

  // One decoded select per field; only the selected field reaches the result
  assign field_acc[0] = '0;

  genvar fi;
  generate
    for (fi = 0; fi < FIELDS_PER_ROW; fi++) begin : g_field
      assign field_raw[fi]   = tbl.b_rdata[fi*DPC_FIELD_W +: DPC_FIELD_W];
      assign sel_hot[fi]     = (s1_sel_ff == DPC_SEL_W'(fi));
      assign field_acc[fi+1] = field_acc[fi] | (sel_hot[fi] ? field_raw[fi] : '0);
    end
  endgenerate

  assign field_pick    = field_acc[FIELDS_PER_ROW];
  assign classify_done = s1_valid_ff && s1_ip_ff;

  logic                   prio_valid_ff;
  logic [DPC_FIELD_W-1:0] prio_value_ff;
  logic                   prio_bypass_ff;

  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      prio_valid_ff  <= 1'b0;
      prio_bypass_ff <= 1'b0;
    end else begin
      prio_valid_ff  <= classify_done;
      prio_bypass_ff <= s1_valid_ff && !s1_ip_ff;
    end
  end

  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      prio_value_ff <= DPC_PRIO_RESET;
    end else if (classify_done) begin
      prio_value_ff <= field_pick;
    end
  end

  // ==========================================================================
  // Status: last classified code and frame count
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      last_code_ff <= DPC_CODE_RESET;
      last_prio_ff <= DPC_PRIO_RESET;
      seen_ff      <= 1'b0;
    end else if (classify_done) begin
      last_code_ff <= s1_code_ff;
      last_prio_ff <= field_pick;
      seen_ff      <= 1'b1;
    end
  end

  // Count clear by write; a frame in the same cycle still counts
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      count_ff <= DPC_CNT_RESET;
    end else if (wr_lane0 && hit_count) begin
      count_ff <= classify_done ? DPC_CNT_ONE : DPC_CNT_RESET;
    end else if (classify_done) begin
      count_ff <= count_ff + DPC_CNT_ONE;
    end
  end

  // ==========================================================================
  // Outputs
  assign avs_readdata    = readdata_ff;
  assign avs_waitrequest = waitrequest_ff;
  assign prio_valid      = prio_valid_ff;
  assign prio_value      = prio_value_ff;
  assign prio_bypass     = prio_bypass_ff;

endmodule // dpc_classifier

`default_nettype wire

//--- dv/dpc_classifier_assertions.sv
// Port checker for the priority classifier, bound to its top module.
// Assumes one clock domain with nrst as the reset.
`timescale 1ns/1ps
`default_nettype none

module dpc_classifier_assertions
  import dpc_pkg::*;
(
  input wire logic                   clock,            // Core clock
  input wire logic                   nrst,             // Reset, active low
  input wire logic [DPC_ADDR_W-1:0]  avs_address,      // Byte address
  input wire logic                   avs_read,         // Read request
  input wire logic                   avs_write,        // Write request
  input wire logic [DPC_DATA_W-1:0]  avs_writedata,    // Write data
  input wire logic [DPC_BE_W-1:0]    avs_byteenable,   // Byte enables
  input wire logic [DPC_DATA_W-1:0]  avs_readdata,     // Read data
  input wire logic                   avs_waitrequest,  // Stall
  input wire logic                   hdr_valid,        // Header strobe
  input wire logic                   hdr_is_ip,        // IP frame
  input wire logic [DPC_BYTE_W-1:0]  hdr_tos,          // Header byte
  input wire logic                   prio_valid,       // Result pulse
  input wire logic [DPC_FIELD_W-1:0] prio_value,       // Result
  input wire logic                   prio_bypass       // Bypass pulse
);
  import dpc_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // ==========================================================================
  // Lookup path
  property p_lookup_answer; hdr_valid |-> ##2 (prio_valid ^ prio_bypass); endproperty
  a_lookup_answer:
    assert property (p_lookup_answer) else $error("lookup gave no single answer");
  property p_nonip_bypass; hdr_valid && !hdr_is_ip |-> ##2 prio_bypass; endproperty
  a_nonip_bypass:
    assert property (p_nonip_bypass) else $error("non-IP frame not bypassed");
  property p_no_spurious; prio_valid |-> $past(hdr_valid, 2) && $past(hdr_is_ip, 2); endproperty
  a_no_spurious:
    assert property (p_no_spurious) else $error("priority without IP header");
  property p_exclusive; !(prio_valid && prio_bypass); endproperty
  a_exclusive:
    assert property (p_exclusive) else $error("valid and bypass together");
  property p_value_hold; !prio_valid |-> $stable(prio_value); endproperty
  a_value_hold:
    assert property (p_value_hold) else $error("priority changed without result");

  // ==========================================================================
  // Register bus
  property p_bus_answer; (avs_read || avs_write) |-> ##[0:2] !avs_waitrequest; endproperty
  a_bus_answer:
    assert property (p_bus_answer) else $error("bus request not answered");
  property p_wait_pulse; !avs_waitrequest |-> $past(avs_read || avs_write) ##1 avs_waitrequest; endproperty
  a_wait_pulse:
    assert property (p_wait_pulse) else $error("waitrequest low out of turn");
  property p_map_width;
    !avs_waitrequest && avs_read && avs_address[9:6] == 4'h6 |-> avs_readdata[31:8] == 24'h000000;
  endproperty
  a_map_width:
    assert property (p_map_width) else $error("table byte read too wide");
  property p_unmapped;
    !avs_waitrequest && avs_read && avs_address[9:2] < 8'h60 |-> avs_readdata == 32'h00000000;
  endproperty
  a_unmapped:
    assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : dpc_classifier_assertions

bind dpc_classifier dpc_classifier_assertions u_chk (.clock(clock), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .hdr_valid(hdr_valid), .hdr_is_ip(hdr_is_ip), .hdr_tos(hdr_tos), .prio_valid(prio_valid),
  .prio_value(prio_value), .prio_bypass(prio_bypass));

`default_nettype wire

//--- dv/dpc_ingress_model.sv
// Ingress parser model: sends header bytes and collects classifier answers.
// Assumes tasks are entered just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module dpc_ingress_model
  import dpc_pkg::*;
(
  input  wire logic                   clock,        // Core clock
  output logic                        hdr_valid,    // Header strobe
  output logic                        hdr_is_ip,    // IP frame
  output logic      [DPC_BYTE_W-1:0]  hdr_tos,      // Header byte
  input  wire logic                   prio_valid,   // Result pulse
  input  wire logic [DPC_FIELD_W-1:0] prio_value,   // Result
  input  wire logic                   prio_bypass   // Bypass pulse
);
  import dpc_pkg::*;
  logic [2:0] res_q[$];

  initial begin
    hdr_valid = 1'b0;
    hdr_is_ip = 1'b0;
    hdr_tos   = 8'h00;
  end

  task automatic send(input logic [7:0] tos, input logic ip);
    hdr_valid <= 1'b1;
    hdr_tos   <= tos;
    hdr_is_ip <= ip;
    @(posedge clock);
  endtask

  // Idle byte lines do not keep the old value
  task automatic idle();
    hdr_valid <= 1'b0;
    hdr_tos   <= ~hdr_tos;
    hdr_is_ip <= ~hdr_is_ip;
    @(posedge clock);
  endtask

  // Bypass answers take the other priority source
  always @(posedge clock) begin
    if (prio_valid === 1'b1) res_q.push_back({1'b0, prio_value});
    else if (prio_bypass === 1'b1) res_q.push_back(3'h4);
  end
endmodule : dpc_ingress_model

`default_nettype wire

//--- dv/dpc_classifier_tb.sv
// Self-checking bench for the priority classifier.
// Assumes the ingress model in its own file and the bound checker.
`timescale 1ns/1ps
`default_nettype none

module dpc_classifier_tb;
  import dpc_pkg::*;
  logic clock, nrst, avs_read, avs_write, avs_waitrequest, prio_valid, prio_bypass, hdr_valid, hdr_is_ip;
  logic [DPC_ADDR_W-1:0] avs_address;
  logic [DPC_DATA_W-1:0] avs_writedata, avs_readdata, rd;
  logic [DPC_BE_W-1:0] avs_byteenable;
  logic [7:0] hdr_tos;
  logic [1:0] prio_value;
  int failures = 0;
  int total_checks = 0;

  dpc_classifier u_dut (.clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .hdr_valid(hdr_valid),
    .hdr_is_ip(hdr_is_ip), .hdr_tos(hdr_tos), .prio_valid(prio_valid), .prio_value(prio_value),
    .prio_bypass(prio_bypass));
  dpc_ingress_model u_ing (.clock(clock), .hdr_valid(hdr_valid), .hdr_is_ip(hdr_is_ip), .hdr_tos(hdr_tos),
    .prio_valid(prio_valid), .prio_value(prio_value), .prio_bypass(prio_bypass));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ==========================================================================
  // Helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, input logic [3:0] be);
    int n;
    n = 0;
    avs_address    <= {idx, 2'b00};
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= wd;
    avs_byteenable <= be;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) failures++;
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic collect(input int n);
    repeat (40) if (u_ing.res_q.size() < n) @(posedge clock);
    check(u_ing.res_q.size(), n);
  endtask

  function automatic logic [7:0] pat(input int r);
    return 8'(r * 8'h3b + 8'h1d);
  endfunction

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset_values();
    for (int r = 0; r < 16; r++) begin
      bus(1'b0, 8'(8'h60 + r), 32'h0, 4'hf);
      check(rd, 32'h0);
    end
    bus(1'b0, DPC_IDX_CTRL, 32'h0, 4'hf);
    check(rd, 32'h1);
  endtask

  task automatic t_program();
    for (int r = 0; r < 16; r++) bus(1'b1, 8'(8'h60 + r), {24'hffffff, pat(r)}, 4'hf);
    for (int r = 0; r < 16; r++) begin
      bus(1'b0, 8'(8'h60 + r), 32'h0, 4'hf);
      check(rd, {24'h0, pat(r)});
    end
  endtask

  // Every code back to back; low two header bits must not matter
  task automatic t_all_codes();
    logic [7:0] p;
    u_ing.res_q.delete();
    for (int c = 0; c < 64; c++) u_ing.send({6'(c), 2'(c)}, 1'b1);
    u_ing.idle();
    collect(64);
    for (int c = 0; c < 64; c++) begin
      p = pat(c / 4) >> (2 * (c % 4));
      check(u_ing.res_q[c], {1'b0, p[1:0]});
    end
    p = pat(15);
    bus(1'b0, DPC_IDX_STATUS, 32'h0, 4'hf);
    check(rd, {16'h0000, 1'b1, 5'h00, p[7:6], 2'h0, 6'h3f});
    bus(1'b0, DPC_IDX_COUNT, 32'h0, 4'hf);
    check(rd, 32'h40);
    bus(1'b1, DPC_IDX_COUNT, 32'h0, 4'h1);
    bus(1'b0, DPC_IDX_COUNT, 32'h0, 4'hf);
    check(rd, 32'h0);
  endtask

  task automatic t_nonip();
    logic [7:0] p;
    p = pat(2) >> 2;
    u_ing.res_q.delete();
    u_ing.send(8'h24, 1'b1);
    u_ing.send(8'h3c, 1'b0);
    u_ing.idle();
    collect(2);
    check(u_ing.res_q[1], 3'h4);
    check(prio_value, p[1:0]);
    check(u_ing.res_q[0], {1'b0, p[1:0]});
    bus(1'b0, DPC_IDX_COUNT, 32'h0, 4'hf);
    check(rd, 32'h1);
  endtask

  task automatic t_refused();
    bus(1'b0, 8'h50, 32'h0, 4'hf);
    check(rd, 32'h0);
    bus(1'b1, DPC_IDX_MAP_BYTE1, 32'h0000005a, 4'he);
    bus(1'b0, DPC_IDX_MAP_BYTE1, 32'h0, 4'hf);
    check(rd, {24'h0, pat(1)});
  endtask

  task automatic t_disable();
    u_ing.res_q.delete();
    bus(1'b1, DPC_IDX_CTRL, 32'h0, 4'hf);
    u_ing.send(8'h30, 1'b1);
    u_ing.idle();
    collect(1);
    check(u_ing.res_q[0], 3'h4);
    bus(1'b1, DPC_IDX_CTRL, 32'h1, 4'hf);
  endtask

  task automatic t_midreset();
    do_reset();
    u_ing.res_q.delete();
    bus(1'b0, DPC_IDX_MAP_BYTE3, 32'h0, 4'hf);
    check(rd, 32'h0);
    u_ing.send(8'h38, 1'b1);
    u_ing.idle();
    collect(1);
    check(u_ing.res_q[0], 3'h0);
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    nrst           = 1'b0;
    avs_address    = '0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = '0;
    avs_byteenable = '0;
    do_reset();
    t_reset_values();
    t_program();
    t_all_codes();
    t_nonip();
    t_refused();
    t_disable();
    t_midreset();
    stop_test();
  end

  initial begin
    #(40 * 5000);
    failures++;
    stop_test();
  end
endmodule : dpc_classifier_tb

`default_nettype wire
